// ---- core/irq_output_pkg.sv ----
// Constants for the interrupt output control block.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz clock.
package irq_output_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  pin_config_addr   = 8'h54;  // Interrupt pin configuration
	localparam logic [7:0]  source_enable_addr = 8'h58; // Source enable word
	localparam logic [7:0]  source_status_addr = 8'h5c; // Raw source levels, read only
	localparam logic [31:0] pin_config_reset  = 32'h00000000;

	// ****************************************
	// Field positions in the configuration word
	// ****************************************
	localparam int interval_msb  = 31;  // Hold-off interval field, top
	localparam int interval_lsb  = 24;  // Hold-off interval field, bottom
	localparam int restart_bit   = 14;  // Self-clearing restart command
	localparam int active_bit    = 13;  // Hold-off running
	localparam int master_bit    = 12;  // Internal request
	localparam int gate_bit      = 8;   // Output gate
	localparam int polarity_bit  = 4;   // Push-pull level
	localparam int buffer_bit    = 0;   // 1 push-pull, 0 open-drain

	// ****************************************
	// Timing
	// ****************************************
	localparam int clock_mhz     = 250;  // Clock rate in MHz
	localparam int step_us       = 10;   // One interval unit in microseconds
	localparam int step_cycles   = step_us * clock_mhz;  // Cycles per unit

	// ****************************************
	// Bus answers
	// ****************************************
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

endpackage : irq_output_pkg

// ---- core/holdoff_tick.sv ----
// Divider that pulses once per hold-off unit.
// Assumes one clock domain; restart realigns the unit boundary.
`timescale 1ns/1ns
module holdoff_tick
	import irq_output_pkg::*;
#(
	parameter int step_count = step_cycles
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic restart,
	output logic      tick
);

	// Elaboration check on the divider length
	if (step_count < 2 || step_count > 65536) begin : g_bad
		$error("step_count must be 2 to 65536");
	end

	typedef struct packed {
		logic [15:0] count;  // Cycles left in this unit
		logic        tick;   // Unit boundary pulse
	} tick_state_t;

	tick_state_t state_ff;
	tick_state_t nxt_state;

	// ****************************************
	// Divider
	// ****************************************
	// Count down, pulse at zero, reload
	always_comb begin
		nxt_state = state_ff;
		nxt_state.tick = 1'b0;
		if (restart) begin
			nxt_state.count = 16'(step_count - 1);
		end else if (state_ff.count == 16'h0000) begin
			nxt_state.count = 16'(step_count - 1);
			nxt_state.tick = 1'b1;
		end else begin
			nxt_state.count = state_ff.count - 16'h0001;
		end
	end

	// Register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign tick = state_ff.tick;

endmodule : holdoff_tick

// ---- core/irq_output_control.sv ----
// Interrupt output stage: merges sources, hold-off interval, pin driver.
// Assumes AXI4-Lite master on aclk; sources are same-clock levels.
//
// What this block does
// - Eight-bit hold-off field counts ten microsecond steps
// - Zero field stops hold-off, releases pending requests
// - New nonzero interval applies to later interrupts
// - Power event bypasses the hold-off interval
// - Restart bit begins fresh interval, clears itself
// - Active bit shows interval running, pin withheld
// - Master bit shows enabled sources, ignores gate
// - Gate low keeps pin deasserted, status untouched
// - Polarity picks push-pull active level
// - Buffer bit picks open-drain or push-pull driver
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module irq_output_control
	import irq_output_pkg::*;
#(
	parameter int num_sources = 8,            // Ordinary interrupt sources
	parameter int step_count  = step_cycles   // Cycles per hold-off unit
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Interrupt sources
	input  wire logic [num_sources-1:0] irq_sources,
	input  wire logic                   power_event,
	// Interrupt pin as two signals
	output logic                        irq_pin_out,
	output logic                        irq_pin_oe
);

	// Elaboration check on the source count
	if (num_sources < 1 || num_sources > 31) begin : g_bad
		$error("num_sources must be 1 to 31");
	end

	// Divider length must fit the sixteen-bit unit counter
	if (step_count < 2 || step_count > 65536) begin : g_bad_step
		$error("step_count must be 2 to 65536");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                   aw_held;    // Write address captured
		logic [7:0]             aw_addr;    // Captured write address
		logic                   w_held;     // Write data captured
		logic [31:0]            w_data;     // Captured write data
		logic [3:0]             w_strb;     // Captured strobes
		logic                   bvalid;     // Write answer pending
		logic [1:0]             bresp;      // Write answer code
		logic                   rvalid;     // Read answer pending
		logic [31:0]            rdata;      // Read answer data
		logic [1:0]             rresp;      // Read answer code
		logic [7:0]             interval;   // Hold-off length in units
		logic                   gate;       // Output gate
		logic                   polarity;   // Push-pull level
		logic                   push_pull;  // Driver type
		logic [num_sources:0]   enable;     // Enables, top bit is power event
		logic [7:0]             remaining;  // Units left in interval
		logic                   active;     // Interval running
		logic                   asserted;   // Pin currently asserted
		logic                   pin_out;    // Pin output level
		logic                   pin_oe;     // Pin output enable
		logic                   aw_ready;   // Address channel free
		logic                   w_ready;    // Data channel free
		logic                   ar_ready;   // Read channel free
	} ctrl_state_t;

	ctrl_state_t state_ff;
	ctrl_state_t nxt_state;

	logic tick;       // One hold-off unit elapsed
	logic restart;    // Realign the unit divider

	// Apply byte strobes to a 32-bit word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// Hold-off field of a configuration word
	function automatic logic [7:0] interval_field(input logic [31:0] word);
		return word[interval_msb:interval_lsb];
	endfunction : interval_field

	// ****************************************
	// Unit divider
	// ****************************************
	holdoff_tick #(
		.step_count (step_count)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.restart (restart),
		.tick    (tick)
	);

	// ****************************************
	// Request merge
	// ****************************************
	logic                 power_req;    // Enabled power event
	logic                 normal_req;   // Enabled ordinary sources
	logic                 master_req;   // Internal request line
	logic [31:0]          config_word;  // Configuration readback
	logic                 wr_fire;      // Write happens this cycle
	logic                 cfg_write;    // Write to configuration
	logic [31:0]          cfg_new;      // Merged configuration value
	logic                 restart_cmd;  // Restart bit written one
	logic                 zero_write;   // Interval field written zero

	// Merge enabled sources and build the readback word
	// Master request ignores the gate and the interval
	always_comb begin
		power_req   = power_event & state_ff.enable[num_sources];
		normal_req  = |(irq_sources & state_ff.enable[num_sources-1:0]);
		master_req  = power_req | normal_req;
		config_word = '0;
		config_word[interval_msb:interval_lsb] = state_ff.interval;
		config_word[active_bit]   = state_ff.active;
		config_word[master_bit]   = master_req;
		config_word[gate_bit]     = state_ff.gate;
		config_word[polarity_bit] = state_ff.polarity;
		config_word[buffer_bit]   = state_ff.push_pull;
	end

	// Write decode; restart reads back zero so it is self-clearing
	always_comb begin
		wr_fire     = state_ff.aw_held & state_ff.w_held & ~state_ff.bvalid;
		cfg_write   = wr_fire && (state_ff.aw_addr == pin_config_addr);
		cfg_new     = merge_bytes(config_word, state_ff.w_data, state_ff.w_strb);
		restart_cmd = cfg_write && state_ff.w_strb[1] && state_ff.w_data[restart_bit];
		zero_write  = cfg_write && state_ff.w_strb[3] &&
			(interval_field(state_ff.w_data) == 8'h00);
		// Divider held while idle so the first unit is whole
		restart     = restart_cmd | (~state_ff.active);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic pin_on;
		logic start_iv;
		logic [7:0] length;
		pin_on   = 1'b0;
		start_iv = 1'b0;
		length   = state_ff.interval;
		nxt_state = state_ff;

		// Address and data channels, taken in either order
		// A channel refuses new items until the held write is committed
		if (s_axi_awvalid && !state_ff.aw_held) begin
			nxt_state.aw_held = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_ff.w_held) begin
			nxt_state.w_held = 1'b1;
			nxt_state.w_data = s_axi_wdata;
			nxt_state.w_strb = s_axi_wstrb;
		end

		// Register writes
		if (wr_fire) begin
			nxt_state.aw_held = 1'b0;
			nxt_state.w_held  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = resp_okay;
			if (cfg_write) begin
				nxt_state.interval  = interval_field(cfg_new);
				nxt_state.gate      = cfg_new[gate_bit];
				nxt_state.polarity  = cfg_new[polarity_bit];
				nxt_state.push_pull = cfg_new[buffer_bit];
				length              = interval_field(cfg_new);
			end else if (state_ff.aw_addr == source_enable_addr) begin
				nxt_state.enable = (num_sources+1)'(merge_bytes(
					32'(state_ff.enable), state_ff.w_data, state_ff.w_strb));
			end else if (state_ff.aw_addr != source_status_addr) begin
				nxt_state.bresp = resp_slverr;  // Unmapped address
			end
		end
		if (state_ff.bvalid && s_axi_bready) begin
			nxt_state.bvalid = 1'b0;
		end

		// Reads
		// Raw status and master bit are sampled at the address edge
		if (s_axi_arvalid && !state_ff.rvalid) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp  = resp_okay;
			case (s_axi_araddr)
				pin_config_addr:    nxt_state.rdata = config_word;
				source_enable_addr: nxt_state.rdata = 32'(state_ff.enable);
				source_status_addr: nxt_state.rdata = 32'({power_event, irq_sources});
				default: begin
					nxt_state.rdata = '0;
					nxt_state.rresp = resp_slverr;
				end
			endcase
		end
		if (state_ff.rvalid && s_axi_rready) begin
			nxt_state.rvalid = 1'b0;
		end

		// Hold-off countdown, one unit per tick
		// The last tick of the interval releases withheld requests
		if (state_ff.active && tick) begin
			if (state_ff.remaining <= 8'h01) begin
				nxt_state.active    = 1'b0;
				nxt_state.remaining = 8'h00;
			end else begin
				nxt_state.remaining = state_ff.remaining - 8'h01;
			end
		end

		// Pin assertion: gated, withheld during interval except power event
		// Power event ignores the interval but still obeys the gate
		pin_on = state_ff.gate &&
			((normal_req && !state_ff.active) || power_req);
		nxt_state.asserted = pin_on;

		// Interval starts when the pin drops after being asserted
		start_iv = (state_ff.asserted && !pin_on) || restart_cmd;
		if (start_iv && length != 8'h00) begin
			nxt_state.active    = 1'b1;
			nxt_state.remaining = length;
		end
		// Zero wins over a restart in the same write
		if (zero_write) begin
			nxt_state.active    = 1'b0;
			nxt_state.remaining = 8'h00;
		end

		// Driver: open-drain is always active low
		// Open-drain never drives high, so a wired-OR line never fights
		if (state_ff.push_pull) begin
			nxt_state.pin_oe  = 1'b1;
			nxt_state.pin_out = pin_on ~^ state_ff.polarity;
		end else begin
			nxt_state.pin_oe  = pin_on;
			nxt_state.pin_out = 1'b0;
		end

		// Write channel readies follow the held flags, read ready follows the read answer, registered like every output
		nxt_state.aw_ready = ~nxt_state.aw_held;
		nxt_state.w_ready  = ~nxt_state.w_held;
		nxt_state.ar_ready = ~nxt_state.rvalid;
	end

	// Register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff           <= '0;
			state_ff.interval  <= pin_config_reset[interval_msb:interval_lsb];
			state_ff.pin_oe    <= 1'b0;
			state_ff.aw_ready  <= 1'b1;  // Ready high during and after reset
			state_ff.w_ready   <= 1'b1;
			state_ff.ar_ready  <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Every output is read straight from a state flop
	assign s_axi_awready = state_ff.aw_ready;
	assign s_axi_wready  = state_ff.w_ready;
	assign s_axi_bvalid  = state_ff.bvalid;
	assign s_axi_bresp   = state_ff.bresp;
	assign s_axi_arready = state_ff.ar_ready;
	assign s_axi_rvalid  = state_ff.rvalid;
	assign s_axi_rdata   = state_ff.rdata;
	assign s_axi_rresp   = state_ff.rresp;
	assign irq_pin_out   = state_ff.pin_out;
	assign irq_pin_oe    = state_ff.pin_oe;

endmodule : irq_output_control

// ---- tb/irq_output_checker.sv ----
// Checker for the interrupt output block: bus answers and pin levels.
// Assumes writes offer address and data together with full strobes.
`timescale 1ns/1ns
module irq_output_checker
	import irq_output_pkg::*;
#(
	parameter int num_sources = 8,
	parameter int step_count  = step_cycles
) (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic [7:0]             s_axi_awaddr,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic [31:0]            s_axi_wdata,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid,
	input wire logic [num_sources-1:0] irq_sources,
	input wire logic                   power_event,
	input wire logic                   irq_pin_out,
	input wire logic                   irq_pin_oe
);
	// Configuration and enables seen on the bus, and cycles since a write
	typedef struct packed {
		logic [31:0]          cfg;
		logic [num_sources:0] en;
		logic [2:0]           age;
	} snoop_t;
	snoop_t s_ff;     // Snooped state
	snoop_t nxt_s;    // Its next value
	logic   wr_go;    // Address and data taken together
	logic   aged;     // Settings settled
	logic   on;       // Some enabled source active
	logic   asserted; // Pin shows its active level
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign aged  = s_ff.age == 3'h7;
	assign on    = |(irq_sources & s_ff.en[num_sources-1:0]) ||
		(power_event && s_ff.en[num_sources]);
	assign asserted = irq_pin_oe &&
		(!s_ff.cfg[buffer_bit] || irq_pin_out == s_ff.cfg[polarity_bit]);
	// Snoop whole-word writes; any write restarts the age
	always_comb begin
		nxt_s = s_ff;
		if (!aged) nxt_s.age = s_ff.age + 3'h1;
		if (wr_go) nxt_s.age = 3'h0;
		if (wr_go && s_axi_awaddr == pin_config_addr) nxt_s.cfg = s_axi_wdata;
		if (wr_go && s_axi_awaddr == source_enable_addr) nxt_s.en = s_axi_wdata[num_sources:0];
		if (!aresetn) nxt_s = '0;
	end
	always_ff @(posedge aclk) s_ff <= nxt_s;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_gate_blocks: assert property (aged && !s_ff.cfg[gate_bit] |-> !asserted)
		else $error("pin asserted with gate off");
	a_pushpull_drives: assert property (aged && s_ff.cfg[buffer_bit] |-> irq_pin_oe)
		else $error("push-pull pin not driven");
	a_drain_low: assert property (!irq_pin_oe |-> !irq_pin_out)
		else $error("released pin level not low");
	a_power_bypass: assert property ((aged && s_ff.cfg[gate_bit] && s_ff.en[num_sources] && power_event)[*3] |-> asserted)
		else $error("power event withheld");
	a_idle_release: assert property ((aged && !on)[*3] |-> !asserted)
		else $error("pin asserted without request");
	a_quick_deliver: assert property ((aged && s_ff.cfg[gate_bit] && s_ff.cfg[31:24] == 8'h0 && on)[*3] |-> asserted)
		else $error("request withheld with zero interval");
endmodule : irq_output_checker
bind irq_output_control irq_output_checker #(.num_sources(num_sources), .step_count(step_count)) chk (.*);

// ---- tb/irq_host_input.sv ----
// Host side interrupt input: resolves the pin seen by the processor.
// Assumes the pin comes split into drive level and drive enable.
`timescale 1ns/1ns
module irq_host_input (
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level
);
	// Released pin is pulled up, so open-drain idles high
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : irq_host_input

// ---- tb/irq_output_control_test.sv ----
// Testbench for the interrupt output block, driven over its register bus.
// Assumes the checker is bound in; hold-off unit shortened to 4 cycles.
`timescale 1ns/1ns
module irq_output_control_test import irq_output_pkg::*;;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, power_event, irq_pin_out, irq_pin_oe, host_level;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_sources;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, cfg;
	logic [31:0] modes [3] = '{32'h100, 32'h101, 32'h111};
	int          error_cnt, check_count, cyc, t0;
	irq_output_control #(.step_count(4)) DUT (.*);
	irq_host_input host (.pin_out(irq_pin_out), .pin_oe(irq_pin_oe), .pin_level(host_level));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Bus write; each channel released when taken
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr_reg
	// Bus read into rd and rsp
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		rd  = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd_reg
	task automatic setcfg(input logic [31:0] c);
		cfg = c;
		wr_reg(pin_config_addr, c);
		repeat (3) @(posedge aclk);
	endtask : setcfg
	// Host level against the active level of the current mode
	task automatic pin(input logic on);
		check({31'h0, host_level}, {31'h0, ~(on ^ (cfg[buffer_bit] & cfg[polarity_bit]))});
	endtask : pin
	// Drop and re-raise the request; time the withheld gap
	task automatic holdoff(input int n);
		setcfg({n[7:0], 24'h000111});
		irq_sources <= 8'h0;
		t0 = cyc;
		repeat (2) @(posedge aclk);
		rd_reg(pin_config_addr);
		check({31'h0, rd[active_bit]}, 32'h1);
		irq_sources <= 8'h1;
		repeat (2) @(posedge aclk);
		pin(1'b0);
		while (host_level !== 1'b1)
			@(posedge aclk);
		check({31'h0, (cyc - t0) inside {[n * 4 + 2 : n * 4 + 10]}}, 32'h1);
	endtask : holdoff
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_sources, power_event} = '0;
		s_axi_wstrb = 4'hf;
		cfg = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(pin_config_addr);
		check(rd, pin_config_reset);
		wr_reg(source_status_addr, 32'hff);
		check({30'h0, rsp}, {30'h0, resp_okay});
		wr_reg(8'h60, 32'h1);
		check({30'h0, rsp}, {30'h0, resp_slverr});
		rd_reg(8'h60);
		check({30'h0, rsp}, {30'h0, resp_slverr});
		check(rd, 32'h0);
		// Gate off: request visible inside, pin released
		wr_reg(source_enable_addr, 32'h1);
		irq_sources <= 8'h1;
		rd_reg(pin_config_addr);
		check(rd, 32'h1000);
		repeat (8) @(posedge aclk);
		pin(1'b0);
		// Every driver mode asserts, then deasserts with the request
		for (int i = 0; i < 3; i++) begin
			setcfg(modes[i]);
			pin(1'b1);
			irq_sources <= 8'h0;
			repeat (3) @(posedge aclk);
			pin(1'b0);
			irq_sources <= 8'h1;
		end
		holdoff(3);
		holdoff(6);
		// Zero interval hands over a withheld request
		irq_sources <= 8'h0;
		repeat (3) @(posedge aclk);
		irq_sources <= 8'h1;
		setcfg(32'h111);
		pin(1'b1);
		rd_reg(pin_config_addr);
		check(rd, 32'h1111);
		// Restart withholds a standing request; power event still passes
		setcfg(32'h06000111);
		wr_reg(pin_config_addr, 32'h06004111);
		rd_reg(pin_config_addr);
		check(rd, 32'h06003111);
		pin(1'b0);
		wr_reg(source_enable_addr, 32'h101);
		power_event <= 1'b1;
		repeat (8) @(posedge aclk);
		pin(1'b1);
		tally_and_finish();
	end
endmodule : irq_output_control_test
